// ===== analog_meter_output.sv
// Purpose: Four-channel analog indicator driver with threshold LEDs and test walk.
// Assumes: Measurements and ratings arrive on ref_clk_i; selector and button are pins.
// Notes: Channels are rescaled one after another by a single shared divider.
////////////////////////////////////////////////////////////////////////////////
module analog_meter_output
  import meter_out_pkg::*;
#(
  parameter int TIMEOUT = TIMEOUT_CYCLES,
  parameter int DEBOUNCE = DEBOUNCE_CYCLES
)(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [2:0] selector_i,
  input wire logic sel_left_i,
  input wire logic test_btn_i,
  input wire logic meas_valid_i,
  input wire meas_type meas_i,
  input wire logic [15:0] plug_amps_i,
  input wire logic [15:0] rated_volts_i,
  output analog_type channel_one_out_o,
  output analog_type channel_two_out_o,
  output analog_type channel_three_out_o,
  output analog_type channel_four_out_o,
  output logic [3:0] chan_led_o,
  output logic device_led_o,
  output logic [1:0] bus_id_o
);
  typedef enum logic {S_LOAD, S_WAIT} scan_type;
  typedef enum logic [1:0] {T_IDLE, T_ARMED, T_CHAN, T_ALL} test_type;

  logic [3:0] sel_s1_r, sel_s2_r;
  meas_type meas_r;
  logic [15:0] cur_fs_r, cur_fs_nxt, volt_fs_r, volt_fs_nxt;
  logic [31:0] pwr_fs_r, tot_fs_r;
  logic [31:0] pwr_ref;
  logic [33:0] tot_ref;
  logic [19:0] cur_need, cur_have, volt_need, volt_have;
  scan_type scan_r, scan_nxt;
  logic [1:0] ch_r, ch_nxt;
  logic [11:0] live_u_r [4];
  logic [11:0] test_u_r [4];
  logic [3:0] live_led_r, live_led_nxt;
  qty_type kind;
  logic [31:0] raw, num, den;
  logic [15:0] pf_mag;
  logic led_hit, start, done;
  logic [11:0] frac, test_u;
  test_type tst_r, tst_nxt;
  logic [1:0] tsel_r, tsel_nxt;
  logic [30:0] timer_r, timer_nxt;
  logic press;
  analog_type out_r [4];
  analog_type out_nxt [4];
  logic [3:0] led_r, led_nxt;
  logic dev_led_r;
  logic [1:0] bus_id_r;

  ////////////////////////////////////////////////////////////////////////////
  // Pin capture and measurement latch.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      sel_s1_r <= 4'h0;
      sel_s2_r <= 4'h0;
      meas_r <= '0;
    end
    else
    begin
      sel_s1_r <= {sel_left_i, selector_i};
      sel_s2_r <= sel_s1_r;
      if (meas_valid_i)
        meas_r <= meas_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Full-scale trackers step once per clock toward the smallest valid multiple.
  // Stepping avoids a divider here; a plug change settles within a few hundred clocks.
  always_comb
  begin
    cur_need = 20'(plug_amps_i) * CUR_FACTOR;
    cur_have = 20'(cur_fs_r) * TENTHS;
    volt_need = 20'(rated_volts_i) * VOLT_FACTOR;
    volt_have = 20'(volt_fs_r) * TENTHS;
    cur_fs_nxt = cur_fs_r;
    volt_fs_nxt = volt_fs_r;
    if (cur_have < cur_need)
      cur_fs_nxt = cur_fs_r + CUR_STEP[15:0];
    else if (cur_fs_r != 16'h0 && cur_have - CUR_STEP * TENTHS >= cur_need)
      cur_fs_nxt = cur_fs_r - CUR_STEP[15:0];
    if (volt_have < volt_need)
      volt_fs_nxt = volt_fs_r + VOLT_STEP[15:0];
    else if (volt_fs_r != 16'h0 && volt_have - VOLT_STEP * TENTHS >= volt_need)
      volt_fs_nxt = volt_fs_r - VOLT_STEP[15:0];
    pwr_ref = 32'(plug_amps_i) * 32'(rated_volts_i);
    tot_ref = 34'(pwr_ref) * 34'h3;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      cur_fs_r <= 16'h0;
      volt_fs_r <= 16'h0;
      pwr_fs_r <= PWR_FS[0];
      tot_fs_r <= PWR_FS[0];
    end
    else
    begin
      cur_fs_r <= cur_fs_nxt;
      volt_fs_r <= volt_fs_nxt;
      pwr_fs_r <= power_full_scale({2'b00, pwr_ref});
      tot_fs_r <= power_full_scale(tot_ref);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quantity routing for the channel under scan.
  always_comb
  begin
    kind = Q_CUR;
    raw = 32'h0;
    case (sel_s2_r[2:0])
      SEL_I:
      begin
        kind = Q_CUR;
        case (ch_r)
          2'h0: raw = 32'(meas_r.i_l1);
          2'h1: raw = 32'(meas_r.i_l2);
          2'h2: raw = 32'(meas_r.i_l3);
          default: raw = 32'(meas_r.i_n);
        endcase
      end
      SEL_V:
      begin
        kind = Q_VOLT;
        case (ch_r)
          2'h0: raw = 32'(meas_r.v_12);
          2'h1: raw = 32'(meas_r.v_23);
          2'h2: raw = 32'(meas_r.v_31);
          default: raw = 32'(meas_r.v_1n);
        endcase
      end
      SEL_P:
      begin
        kind = (ch_r == 2'h3) ? Q_TOT : Q_PWR;
        case (ch_r)
          2'h0: raw = meas_r.p_l1;
          2'h1: raw = meas_r.p_l2;
          2'h2: raw = meas_r.p_l3;
          default: raw = meas_r.s_tot;
        endcase
      end
      SEL_F:
      begin
        case (ch_r)
          2'h0: begin kind = Q_FREQ; raw = 32'(meas_r.freq); end
          2'h1: begin kind = Q_VOLT; raw = 32'(meas_r.v_mean); end
          2'h2: begin kind = Q_TOT; raw = meas_r.p_tot; end
          default: begin kind = Q_PF; raw = 32'(meas_r.pf_mean); end
        endcase
      end
      default:
      begin
        kind = (ch_r == 2'h3) ? Q_UNBAL : Q_PF;
        case (ch_r)
          2'h0: raw = 32'(meas_r.pf_l1);
          2'h1: raw = 32'(meas_r.pf_l2);
          2'h2: raw = 32'(meas_r.pf_l3);
          default: raw = 32'(meas_r.unbal);
        endcase
      end
    endcase
  end

  // Offset, span, LED limit and test value of each quantity kind.
  always_comb
  begin
    pf_mag = raw[15] ? 16'h0 - raw[15:0] : raw[15:0];
    num = raw;
    den = 32'(cur_fs_r);
    test_u = DAC_FULL;
    led_hit = ({3'b000, raw} * 35'h5) > {3'b000, den};
    case (kind)
      Q_VOLT: den = 32'(volt_fs_r);
      Q_PWR: den = pwr_fs_r;
      Q_TOT: den = tot_fs_r;
      Q_FREQ:
      begin
        num = (raw[15:0] > FREQ_MIN) ? 32'(raw[15:0] - FREQ_MIN) : 32'h0;
        den = FREQ_SPAN;
        test_u = DAC_MID;
      end
      Q_PF:
      begin
        if (!raw[15])
          num = (pf_mag < PF_UNITY) ? 32'(PF_MID + PF_UNITY - pf_mag) : 32'(PF_MID);
        else
          num = (pf_mag > PF_FLOOR) ? 32'(pf_mag - PF_FLOOR) : 32'h0;
        den = PF_SPAN;
        test_u = DAC_MID;
      end
      Q_UNBAL: den = UNBAL_SPAN;
      default: den = 32'(cur_fs_r);
    endcase
    if (kind == Q_FREQ)
      led_hit = raw[15:0] > FREQ_MIN;
    else if (kind == Q_PF)
      led_hit = pf_mag > PF_LED;
    else if (kind == Q_VOLT || kind == Q_PWR || kind == Q_TOT || kind == Q_UNBAL)
      led_hit = ({3'b000, raw} * 35'h5) > {3'b000, den};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Round-robin scan: each channel is rescaled in turn, even during test mode.
  always_comb
  begin
    scan_nxt = scan_r;
    ch_nxt = ch_r;
    start = 1'b0;
    live_led_nxt = live_led_r;
    case (scan_r)
      S_LOAD:
      begin
        start = 1'b1;
        scan_nxt = S_WAIT;
      end
      S_WAIT:
      begin
        if (done)
        begin
          live_led_nxt[ch_r] = led_hit;
          ch_nxt = ch_r + 2'h1;
          scan_nxt = S_LOAD;
        end
      end
      default: scan_nxt = S_LOAD;
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      scan_r <= S_LOAD;
      ch_r <= 2'h0;
      live_led_r <= 4'h0;
      live_u_r <= '{default: 12'h0};
      test_u_r <= '{default: 12'h0};
    end
    else
    begin
      scan_r <= scan_nxt;
      ch_r <= ch_nxt;
      live_led_r <= live_led_nxt;
      if (scan_r == S_WAIT && done)
      begin
        live_u_r[ch_r] <= frac;
        test_u_r[ch_r] <= test_u;
      end
    end
  end

  frac_scaler u_scaler (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .start_i(start),
    .num_i(num),
    .den_i(den),
    .done_o(done),
    .frac_o(frac)
  );

  button_debounce #(.CYCLES(DEBOUNCE)) u_button (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .btn_i(test_btn_i),
    .press_o(press)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Test walk: armed, channel one to four, all LEDs, back to channel one.
  always_comb
  begin
    tst_nxt = tst_r;
    tsel_nxt = tsel_r;
    timer_nxt = (tst_r == T_IDLE || press) ? 31'h0 : timer_r + 31'h1;
    case (tst_r)
      T_IDLE: if (press) tst_nxt = T_ARMED;
      T_ARMED, T_ALL:
      begin
        if (press)
        begin
          tst_nxt = T_CHAN;
          tsel_nxt = 2'h0;
        end
      end
      T_CHAN:
      begin
        if (press && tsel_r == 2'h3)
          tst_nxt = T_ALL;
        else if (press)
          tsel_nxt = tsel_r + 2'h1;
      end
      default: tst_nxt = T_IDLE;
    endcase
    if (tst_r != T_IDLE && !press && timer_r == 31'(TIMEOUT - 1))
      tst_nxt = T_IDLE;
  end

  // Output images; both forms share one code so they can never disagree.
  always_comb
  begin
    for (int k = 0; k < 4; k++)
    begin
      out_nxt[k].volt_code = live_u_r[k];
      if (tst_r != T_IDLE)
        out_nxt[k].volt_code = (tst_r == T_CHAN && tsel_r == 2'(k)) ? test_u_r[k] : 12'h0;
      out_nxt[k].curr_code = CUR_ZERO + 13'(out_nxt[k].volt_code);
    end
    case (tst_r)
      T_IDLE: led_nxt = live_led_r;
      T_CHAN: led_nxt = 4'h1 << tsel_r;
      T_ALL: led_nxt = 4'hF;
      default: led_nxt = 4'h0;
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      tst_r <= T_IDLE;
      tsel_r <= 2'h0;
      timer_r <= 31'h0;
      out_r <= '{default: '{volt_code: 12'h0, curr_code: CUR_ZERO}};
      led_r <= 4'h0;
      dev_led_r <= 1'b0;
      bus_id_r <= BUS_ID_RIGHT;
    end
    else
    begin
      tst_r <= tst_nxt;
      tsel_r <= tsel_nxt;
      timer_r <= timer_nxt;
      out_r <= out_nxt;
      led_r <= led_nxt;
      dev_led_r <= (tst_r != T_IDLE);
      bus_id_r <= sel_s2_r[3] ? BUS_ID_LEFT : BUS_ID_RIGHT;
    end
  end

  assign channel_one_out_o = out_r[0];
  assign channel_two_out_o = out_r[1];
  assign channel_three_out_o = out_r[2];
  assign channel_four_out_o = out_r[3];
  assign chan_led_o = led_r;
  assign device_led_o = dev_led_r;
  assign bus_id_o = bus_id_r;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  chk_forms_match:
    assert property (channel_one_out_o.curr_code == CUR_ZERO + 13'(channel_one_out_o.volt_code)
      && channel_four_out_o.curr_code == CUR_ZERO + 13'(channel_four_out_o.volt_code))
    else $error("Voltage and current forms disagree.");
  chk_test_blanks:
    assert property (tst_r == T_ARMED |=> channel_one_out_o.volt_code == 12'h0
      && channel_four_out_o.volt_code == 12'h0)
    else $error("Live value reached a channel in test mode.");
  chk_device_led:
    assert property (tst_r == T_IDLE && press |-> ##2 device_led_o)
    else $error("Device LED not lit after entering test.");
  chk_all_leds:
    assert property (tst_r == T_CHAN && tsel_r == 2'h3 && press |-> ##2 chan_led_o == 4'hF)
    else $error("Press on channel four did not light all LEDs.");
  chk_wrap_one:
    assert property (tst_r == T_ALL && press |-> ##2 chan_led_o == 4'h1
      && channel_one_out_o.volt_code == test_u_r[0])
    else $error("Press after all-LED step did not reselect channel one.");
  chk_timeout_exit:
    assert property (tst_r != T_IDLE && !press && timer_r == 31'(TIMEOUT - 1) |=> tst_r == T_IDLE)
    else $error("Test mode outlived its timeout.");
  chk_press_restart:
    assert property (tst_r != T_IDLE && press |=> timer_r == 31'h0)
    else $error("Press did not restart the test timer.");
  // The first edge after reset still shows the reset full scale, so it is skipped.
  chk_power_range:
    assert property ($past(rst_b_i) && $past(pwr_ref) < PWR_FS[11]
      |-> pwr_fs_r > $past(pwr_ref))
    else $error("Power full scale below its reference.");

  cov_enter_test: cover property (tst_r == T_IDLE && press);
  cov_all_leds: cover property (tst_r == T_ALL);
  cov_timeout: cover property (tst_r != T_IDLE ##1 tst_r == T_IDLE);
endmodule

// ===== analog_meter_output_tb.sv
// Purpose: Self-checking bench of the analog meter output block.
// Assumes: TIMEOUT 200 and DEBOUNCE 4 shorten the long counts.
// Notes: One fixed measurement set serves every selector row.
////////////////////////////////////////////////////////////////////////////////
module analog_meter_output_tb
  import meter_out_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [2:0] sel;
    logic [0:3][11:0] c;
    logic [3:0] led;
  } row_type;
  localparam row_type ROWS [5] = '{
    '{SEL_I, {12'hFA0, 12'h7D0, 12'h000, 12'h3E8}, 4'hB},
    '{SEL_V, {12'hFA0, 12'h7D0, 12'h000, 12'hFA0}, 4'hB},
    '{SEL_P, {12'hFA0, 12'h7D0, 12'h000, 12'h7D0}, 4'hB},
    '{SEL_F, {12'h7D0, 12'hFA0, 12'hFA0, 12'h7D0}, 4'hF},
    '{3'h7, {12'h7D0, 12'h000, 12'hFA0, 12'h7D0}, 4'h9}};
  logic clk, rst_b, left, btn, mvalid, dev_led;
  logic [2:0] sel;
  logic [15:0] plug, volts;
  logic [3:0] led;
  logic [1:0] bus_id;
  logic [0:3][11:0] t;
  meas_type meas, m;
  analog_type ch [4];
  int miscompares = 0;
  int total_checks = 0;

  meas_source src (.ref_clk_i(clk), .meas_valid_o(mvalid), .meas_o(meas));

  analog_meter_output #(.TIMEOUT(200), .DEBOUNCE(4)) dut (
    .ref_clk_i(clk), .rst_b_i(rst_b), .selector_i(sel), .sel_left_i(left),
    .test_btn_i(btn), .meas_valid_i(mvalid), .meas_i(meas), .plug_amps_i(plug),
    .rated_volts_i(volts), .channel_one_out_o(ch[0]), .channel_two_out_o(ch[1]),
    .channel_three_out_o(ch[2]), .channel_four_out_o(ch[3]), .chan_led_o(led),
    .device_led_o(dev_led), .bus_id_o(bus_id));

  // Free-running 50 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input string name, input logic [12:0] seen, input logic [12:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic expect_out(input logic [0:3][11:0] c, input logic [3:0] l);
    for (int k = 0; k < 4; k++)
    begin
      check("volt_code", {1'b0, ch[k].volt_code}, {1'b0, c[k]});
      check("curr_code", ch[k].curr_code, {1'b0, c[k]} + 13'h3E8);
    end
    check("chan_led", {9'h000, led}, {9'h000, l});
  endtask

  // Hold the pin for len cycles, then leave it released long enough to settle.
  task automatic press(input int len);
    @(negedge clk);
    btn = 1'b1;
    repeat (len) @(negedge clk);
    btn = 1'b0;
    repeat (12) @(negedge clk);
  endtask

  task automatic test_done();
    if (miscompares == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Whole run needs about 2600 cycles; a hang is cut off well past that.
  initial
  begin
    repeat (10000) @(posedge clk);
    miscompares++;
    test_done();
  end

  initial
  begin
    rst_b = 1'b0;
    sel = SEL_I;
    left = 1'b1;
    btn = 1'b0;
    plug = 16'h640;
    volts = 16'h190;
    m = '0;
    {m.i_l1, m.i_l2, m.i_n} = {16'h7D0, 16'h3E8, 16'h1F4};
    {m.v_12, m.v_23, m.v_1n, m.v_mean} = {16'h1C2, 16'h0E1, 16'h384, 16'h1C2};
    {m.p_l1, m.p_l2, m.s_tot, m.p_tot} = {32'hF4240, 32'h7A120, 32'hF4240, 32'h1E8480};
    {m.freq, m.pf_l1, m.pf_l2, m.pf_l3} = {16'h157C, 16'h3E8, 16'hFD44, 16'h2BC};
    {m.pf_mean, m.unbal} = {16'h3E8, 16'h0FA};
    repeat (2) @(negedge clk);
    expect_out('0, 4'h0);
    check("device_led", {12'h000, dev_led}, 13'h0000);
    rst_b = 1'b1;
    src.put(m, 0);
    src.put(m, 5);
    // Selector rows: channel mapping, full scales, saturation and LED limits.
    foreach (ROWS[r])
    begin
      sel = ROWS[r].sel;
      repeat (250) @(negedge clk);
      expect_out(ROWS[r].c, ROWS[r].led);
    end
    check("bus_id", {11'h000, bus_id}, 13'h0001);
    sel = SEL_I;
    repeat (250) @(negedge clk);
    press(2);
    check("device_led", {12'h000, dev_led}, 13'h0000);
    press(10);
    check("device_led", {12'h000, dev_led}, 13'h0001);
    expect_out('0, 4'h0);
    for (int k = 0; k < 4; k++)
    begin
      press(10);
      t = '0;
      t[k] = DAC_FULL;
      expect_out(t, 4'h1 << k);
    end
    press(10);
    expect_out('0, 4'hF);
    press(10);
    expect_out({DAC_FULL, 36'h0}, 4'h1);
    repeat (150) @(negedge clk);
    check("device_led", {12'h000, dev_led}, 13'h0001);
    repeat (100) @(negedge clk);
    check("device_led", {12'h000, dev_led}, 13'h0000);
    repeat (80) @(negedge clk);
    expect_out(ROWS[0].c, ROWS[0].led);
    left = 1'b0;
    repeat (10) @(negedge clk);
    check("bus_id", {11'h000, bus_id}, 13'h0002);
    // Frequency test value is mid-scale like pf, unlike the full-scale test of the other kinds.
    sel = SEL_F;
    repeat (250) @(negedge clk);
    press(10);
    press(10);
    expect_out({DAC_MID, 36'h0}, 4'h1);
    // Reset in mid-test must clear everything, and a fresh measurement must come through.
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    expect_out('0, 4'h0);
    check("device_led", {12'h000, dev_led}, 13'h0000);
    check("bus_id", {11'h000, bus_id}, 13'h0002);
    rst_b = 1'b1;
    src.put(m, 0);
    repeat (250) @(negedge clk);
    expect_out(ROWS[3].c, ROWS[3].led);
    test_done();
  end
endmodule

// ===== button_debounce.sv
// Purpose: Synchronise and debounce the test button into one pulse per press.
// Assumes: Button pin is active high and asynchronous to ref_clk_i.
// Notes: The level must hold for CYCLES clocks before it is believed.
////////////////////////////////////////////////////////////////////////////////
module button_debounce
  import meter_out_pkg::*;
#(
  parameter int CYCLES = DEBOUNCE_CYCLES
)(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic btn_i,
  output logic press_o
);
  logic sync1_r, sync2_r, stable_r, stable_nxt, press_r, press_nxt;
  logic [31:0] cnt_r, cnt_nxt;

  // A new level restarts the count, so chatter never reaches the stable copy.
  always_comb
  begin
    stable_nxt = stable_r;
    press_nxt = 1'b0;
    cnt_nxt = '0;
    if (sync2_r != stable_r)
    begin
      cnt_nxt = cnt_r + 32'h1;
      if (cnt_r == 32'(CYCLES - 1))
      begin
        stable_nxt = sync2_r;
        press_nxt = sync2_r;
        cnt_nxt = '0;
      end
    end
  end

  // Two flip-flops guard the pin before anything reads it.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      stable_r <= 1'b0;
      press_r <= 1'b0;
      cnt_r <= '0;
    end
    else
    begin
      sync1_r <= btn_i;
      sync2_r <= sync1_r;
      stable_r <= stable_nxt;
      press_r <= press_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign press_o = press_r;
endmodule

// ===== frac_scaler.sv
// Purpose: Turn a quantity and its full scale into a DAC code from 0 to 4000.
// Assumes: start_i only while idle; operands stay valid until done_o.
// Notes: Twelve-bit fraction by restoring division, thirteen cycles per result, one cycle when saturated.
////////////////////////////////////////////////////////////////////////////////
module frac_scaler
  import meter_out_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic [31:0] num_i,
  input wire logic [31:0] den_i,
  output logic done_o,
  output logic [11:0] frac_o
);
  typedef enum logic {F_IDLE, F_RUN} fstate_type;
  fstate_type st_r, st_nxt;
  logic [32:0] rem_r, rem_nxt, rem2;
  logic [11:0] quo_r, quo_nxt, frac_r, frac_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic done_r, done_nxt, ge;
  logic [23:0] prod;

  // Saturate at or above full scale so the top code is exact.
  always_comb
  begin
    st_nxt = st_r;
    rem_nxt = rem_r;
    quo_nxt = quo_r;
    bit_nxt = bit_r;
    frac_nxt = frac_r;
    done_nxt = 1'b0;
    rem2 = {rem_r[31:0], 1'b0};
    ge = (rem2 >= {1'b0, den_i});
    prod = 24'h0;
    case (st_r)
      F_IDLE:
      begin
        if (start_i && (num_i >= den_i || den_i == 32'h0))
        begin
          frac_nxt = DAC_FULL;
          done_nxt = 1'b1;
        end
        else if (start_i)
        begin
          rem_nxt = {1'b0, num_i};
          quo_nxt = 12'h0;
          bit_nxt = 4'h0;
          st_nxt = F_RUN;
        end
      end
      F_RUN:
      begin
        rem_nxt = ge ? rem2 - {1'b0, den_i} : rem2;
        quo_nxt = {quo_r[10:0], ge};
        bit_nxt = bit_r + 4'h1;
        if (bit_r == BITS_FRAC - 4'h1)
        begin
          prod = 24'(quo_nxt) * 24'(DAC_FULL);
          frac_nxt = prod[23:12];
          done_nxt = 1'b1;
          st_nxt = F_IDLE;
        end
      end
      default: st_nxt = F_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      st_r <= F_IDLE;
      rem_r <= '0;
      quo_r <= '0;
      bit_r <= '0;
      frac_r <= '0;
      done_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      rem_r <= rem_nxt;
      quo_r <= quo_nxt;
      bit_r <= bit_nxt;
      frac_r <= frac_nxt;
      done_r <= done_nxt;
    end
  end

  assign done_o = done_r;
  assign frac_o = frac_r;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  chk_scale_full:
    assert property (st_r == F_IDLE && start_i && num_i >= den_i |=> done_o && frac_o == DAC_FULL)
    else $error("Full-scale input did not give the top code.");
  chk_scale_zero:
    assert property (st_r == F_IDLE && start_i && num_i == 32'h0 && den_i != 32'h0
      |-> ##13 done_o && frac_o == 12'h0)
    else $error("Zero input did not give the bottom code.");
endmodule

// ===== meas_source.sv
// Purpose: Measurement source on the module bus side of the meter block.
// Assumes: Values change just after the falling edge of ref_clk_i.
// Notes: Between pulses the data shows inverted last data, never a stale copy.
////////////////////////////////////////////////////////////////////////////////
module meas_source
  import meter_out_pkg::*;
(
  input wire logic ref_clk_i,
  output logic meas_valid_o,
  output meas_type meas_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Only this one source feeds one block, inside the two-module bus limit.
  initial
  begin
    meas_valid_o = 1'b0;
    meas_o = '0;
  end

  // One-cycle valid pulse; a gap models a slow source.
  task automatic put(input meas_type m, input int gap);
    @(negedge ref_clk_i);
    meas_o = m;
    meas_valid_o = 1'b1;
    @(negedge ref_clk_i);
    meas_valid_o = 1'b0;
    meas_o = ~m;
    repeat (gap) @(negedge ref_clk_i);
  endtask
endmodule

// ===== meter_out_pkg.sv
// Purpose: Shared constants, types and lookups of the analog meter output block.
// Assumes: 50 MHz ref_clk_i; DAC codes 4000 = 10 V and 5000 = 20 mA.
// Notes: Power factor is signed thousandths, negative meaning capacitive.
// How it works
// - Four independent analog channels, each carrying one selected quantity.
// - Voltage and current forms driven together with identical scaled value.
// - Left-half selector gives bus identity 1; second module uses right half.
// - Channel LED lights above 20% full scale, pf 0.8, or 45 Hz.
// - Current selection: phase 1-3 currents, then neutral current, linear.
// - Current full scale is plug times 1.2, rounded up to 100 A.
// - Zero maps to 0 V/4 mA, full scale maps to 10 V/20 mA.
// - Voltage selection: L1-L2, L2-L3, L3-L1, then L1-N voltage.
// - Voltage full scale is rated voltage times 1.1, rounded up to 50 V.
// - Power selection: phase 1-3 active power, then total apparent power.
// - Power reference is plug times voltage; totals use three times that.
// - Power full scale comes from a thirteen-step range lookup.
// - Frequency selection: frequency, mean voltage, total power, mean pf.
// - Frequency spans 45 Hz at minimum to 65 Hz at maximum.
// - Pf selection: phase 1-3 power factors, then current unbalance.
// - Pf 0.7 capacitive minimum, unity mid-scale, 0.7 inductive maximum.
// - Unbalance spans 0% at minimum to 50% at maximum.
// - Button enters test mode, device LED on, live values withheld.
// - Each press selects next channel, drives its test value, clears others.
// - Press on channel four lights all LEDs, no value; next selects one.
// - Thirty seconds without press leaves test mode, live values return.
////////////////////////////////////////////////////////////////////////////////
package meter_out_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int TIMEOUT_S = 30;
  localparam int DEBOUNCE_MS = 20;
  localparam int TIMEOUT_CYCLES = TIMEOUT_S * CLK_HZ;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam logic [11:0] DAC_FULL = 12'hFA0;
  localparam logic [11:0] DAC_MID = 12'h7D0;
  localparam logic [12:0] CUR_ZERO = 13'h3E8;
  localparam logic [3:0] BITS_FRAC = 4'hC;
  localparam logic [2:0] SEL_I = 3'h0;
  localparam logic [2:0] SEL_V = 3'h1;
  localparam logic [2:0] SEL_P = 3'h2;
  localparam logic [2:0] SEL_F = 3'h3;
  localparam logic [2:0] SEL_PF = 3'h4;
  localparam logic [1:0] BUS_ID_LEFT = 2'h1;
  localparam logic [1:0] BUS_ID_RIGHT = 2'h2;
  localparam logic [19:0] CUR_STEP = 20'h64;
  localparam logic [19:0] CUR_FACTOR = 20'hC;
  localparam logic [19:0] VOLT_STEP = 20'h32;
  localparam logic [19:0] VOLT_FACTOR = 20'hB;
  localparam logic [19:0] TENTHS = 20'hA;
  localparam logic [15:0] FREQ_MIN = 16'h1194;
  localparam logic [31:0] FREQ_SPAN = 32'h7D0;
  localparam logic [15:0] PF_FLOOR = 16'h2BC;
  localparam logic [15:0] PF_UNITY = 16'h3E8;
  localparam logic [15:0] PF_MID = 16'h12C;
  localparam logic [15:0] PF_LED = 16'h320;
  localparam logic [31:0] PF_SPAN = 32'h258;
  localparam logic [31:0] UNBAL_SPAN = 32'h1F4;
  localparam logic [31:0] PWR_FS [13] = '{32'hC350, 32'h186A0, 32'h30D40, 32'h493E0,
    32'h61A80, 32'h7A120, 32'hF4240, 32'h1E8480, 32'h2DC6C0, 32'h4C4B40, 32'h989680,
    32'h1312D00, 32'h1C9C380};

  typedef enum logic [2:0] {Q_CUR, Q_VOLT, Q_PWR, Q_TOT, Q_FREQ, Q_PF, Q_UNBAL} qty_type;

  typedef struct packed {
    logic [15:0] i_l1, i_l2, i_l3, i_n;
    logic [15:0] v_12, v_23, v_31, v_1n, v_mean;
    logic [31:0] p_l1, p_l2, p_l3, p_tot, s_tot;
    logic [15:0] freq;
    logic [15:0] pf_l1, pf_l2, pf_l3, pf_mean;
    logic [15:0] unbal;
  } meas_type;

  typedef struct packed {
    logic [11:0] volt_code;
    logic [12:0] curr_code;
  } analog_type;

  // Smallest table step above the reference; the top step catches the rest.
  function automatic logic [31:0] power_full_scale(input logic [33:0] pref);
    logic [31:0] fs;
    fs = PWR_FS[12];
    for (int k = 11; k >= 0; k--)
    begin
      if (pref < {2'b00, PWR_FS[k]})
        fs = PWR_FS[k];
    end
    return fs;
  endfunction
endpackage
